/* inc/wbc_pkg.sv */
// Purpose : Shared constants and types for the LED boost control block
// Assumes : 10 MHz system clock
// Notes   : Times are kept in their own unit; cycle counts derive from them
package wbc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10000000;
  localparam int SW_HZ           = 600000;
  localparam int OFF_TIME_US10   = 25000;   // 2.5 ms in 0.1 us units
  localparam int STEP_TIME_US    = 213;     // Soft-start step length
  localparam int HALF_ILIM_US    = 5000;    // 5 ms reduced limit window
  localparam int OFF_CYC  = (OFF_TIME_US10 * (CLK_HZ / 1000000) + 9) / 10;
  localparam int STEP_CYC = STEP_TIME_US * (CLK_HZ / 1000000);
  localparam int HALF_CYC = HALF_ILIM_US * (CLK_HZ / 1000000);
  localparam int SW_DIV   = CLK_HZ / SW_HZ;  // Round down to 16
  localparam int SS_STEPS = 32;
  localparam int OVP_CYC  = 8;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int          REF_W       = 5;
  localparam logic [4:0]  REF_DEFAULT = 5'h1f;  // Full scale, 200 mV
  localparam int          PWM_W       = 8;
  localparam int          CNT_W       = 17;

  // Driver states
  typedef enum logic [2:0] {
    WBC_OFF, WBC_RAMP, WBC_RUN, WBC_FAULT, WBC_OPEN
  } wbc_state_t;

  // Protection inputs from the analog side
  typedef struct packed {
    logic uvlo;       // Input below lockout level (hysteresis analog)
    logic hot;        // Junction over trip (hysteresis analog)
    logic ovp;        // Switch node above overvoltage threshold
    logic fault;      // Other driver fault
  } wbc_prot_t;

  // Controls toward the analog side
  typedef struct packed {
    logic             active;     // Bias and oscillator on
    logic             drv_on;     // Driver enabled
    logic             sw_gate;    // Switch gate drive
    logic             half_ilim;  // Current limit halved
    logic [REF_W-1:0] ref_code;   // Reference step in use
    logic             ref_chop;   // Chopped reference enable
  } wbc_ctl_t;

endpackage

/* rtl/wbc_sync.sv */
// Purpose : Two-flop synchroniser for one level from outside the domain
// Assumes : Single clock, synchronous active-low reset
// Notes   : The first stage feeds only the second
`timescale 1ns/1ps
module wbc_sync (
  input  wire logic i_clk,     // System clock
  input  wire logic i_rst_n,   // Sync reset, active low
  input  wire logic i_d,       // Asynchronous level
  output logic      o_q        // Synchronised level
);
  logic s1;
  logic next_s1;
  logic next_q;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Next values
  always_comb begin
    next_s1 = i_d;
    next_q  = s1;
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1  <= 1'b0;
      o_q <= 1'b0;
    end else begin
      s1  <= next_s1;
      o_q <= next_q;
    end
  end
endmodule

/* rtl/wbc_swclk.sv */
// Purpose : Switching-rate enable and PWM gate for the boost switch
// Assumes : 10 MHz clock, enable pulse once per switching period
// Notes   : Gate is high for the first part of each period
`timescale 1ns/1ps
module wbc_swclk (
  input  wire logic i_clk,     // System clock
  input  wire logic i_rst_n,   // Sync reset, active low
  input  wire logic i_run,     // Switching allowed
  output logic      o_tick,    // One pulse per switching period
  output logic      o_gate     // Switch gate pattern
);
  localparam int DW = $clog2(wbc_pkg::SW_DIV);
  localparam logic [DW-1:0] LAST = DW'(wbc_pkg::SW_DIV - 1);
  localparam logic [DW-1:0] HALF = DW'(wbc_pkg::SW_DIV / 2);

  logic [DW-1:0] cnt;
  logic [DW-1:0] next_cnt;
  logic          next_tick;
  logic          next_gate;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Period counter and gate
  always_comb begin
    next_cnt  = (!i_run || cnt == LAST) ? '0 : cnt + 1'b1;
    next_tick = i_run && (cnt == LAST);
    next_gate = i_run && (next_cnt < HALF);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt    <= '0;
      o_tick <= 1'b0;
      o_gate <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
      o_gate <= next_gate;
    end
  end
endmodule

/* rtl/wbc_top.sv */
// Purpose : Enable, shutdown, soft start and protection of LED boost
// Assumes : 10 MHz clock; control pin asynchronous; analog hysteresis
// Notes   : Register bits arrive as plain ports, no bus in this block
`timescale 1ns/1ps

// Functional notes
// - Standby: bias and oscillator off; register and monitor paths kept.
// - Active while bus power present or LED driver on.
// - Driver enabled by enable bit or by the control pin.
// - Control pin is edge sensitive; host keeps it low at power-up.
// - Enable bit set means control pin is ignored; in open-LED shutdown a pin rising edge still returns the state to off.
// - Bit clear and pin low over 2.5 ms shuts driver down.
// - Feedback reference from five-bit code, default full scale 200 mV.
// - Fault disables driver, clears bit, holds until pin low 2.5 ms.
// - Input undervoltage shuts driver and switch; restarts on recovery.
// - Over-temperature shuts down; released automatically on cooling.
// - Soft start ramps reference in 32 steps of 213 us.
// - Switch current limit halved for 5 ms after ramp start.
// - Overvoltage for eight switching cycles turns switch off, shuts down.
// - After open-LED shutdown, restart needs a pin or bit toggle.
// - Pin steady high regulates to register reference, 0 to 200 mV.
// - PWM on pin chops reference at its duty, then filtered.
// - Switch runs PWM at fixed 600 kHz; the divide by 16 gives 625 kHz.
module wbc_top (
  input  wire logic             i_clk,         // System clock 10 MHz
  input  wire logic             i_rst_n,       // Sync reset, active low
  input  wire logic             i_ctrl_pin,    // Dimming control pin
  input  wire logic             i_enable_bit,  // Driver enable bit value
  input  wire logic             i_enable_wr,   // Pulse: enable bit written
  input  wire logic [4:0]       i_ref_code,    // Feedback reference code
  input  wire logic             i_bus_power,   // Bus power present
  input  wire wbc_pkg::wbc_prot_t i_prot,      // Protection comparators
  output wbc_pkg::wbc_ctl_t     o_ctl,         // Controls to power stage
  output wbc_pkg::wbc_state_t   o_state,       // Driver state
  output logic                  o_clr_enable   // Pulse: clear enable bit
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic ctrl_s;
  logic bus_s;
  logic uvlo_s;
  logic hot_s;
  logic ovp_s;
  logic flt_s;

  wbc_sync u_sync_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_ctrl_pin), .o_q(ctrl_s));
  wbc_sync u_sync_bus  (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_bus_power), .o_q(bus_s));
  wbc_sync u_sync_uvlo (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_prot.uvlo), .o_q(uvlo_s));
  wbc_sync u_sync_hot  (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_prot.hot), .o_q(hot_s));
  wbc_sync u_sync_ovp  (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_prot.ovp), .o_q(ovp_s));
  wbc_sync u_sync_flt  (.i_clk(i_clk), .i_rst_n(i_rst_n),
                        .i_d(i_prot.fault), .o_q(flt_s));

  // ----------------------------------------------------------------
  // Switching clock
  // ----------------------------------------------------------------
  logic sw_tick;
  logic sw_gate;
  logic sw_run;

  wbc_swclk u_swclk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(sw_run),
                     .o_tick(sw_tick), .o_gate(sw_gate));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int            CW        = wbc_pkg::CNT_W;
  localparam logic [CW-1:0] OFF_LAST  = CW'(wbc_pkg::OFF_CYC);
  localparam logic [CW-1:0] STEP_LAST = CW'(wbc_pkg::STEP_CYC - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(wbc_pkg::HALF_CYC - 1);
  localparam logic [5:0] SS_LAST = 6'(wbc_pkg::SS_STEPS - 1);
  localparam logic [3:0] OVP_LAST = 4'(wbc_pkg::OVP_CYC);

  wbc_pkg::wbc_state_t state, next_state;
  logic                        ctrl_d, next_ctrl_d;
  logic                        bit_d, next_bit_d;
  logic [wbc_pkg::CNT_W-1:0]   low_cnt, next_low_cnt;
  logic                        low_long, next_low_long;
  logic [wbc_pkg::CNT_W-1:0]   step_cnt, next_step_cnt;
  logic [5:0]                  ss_idx, next_ss_idx;
  logic [wbc_pkg::CNT_W-1:0]   half_cnt, next_half_cnt;
  logic                        half_on, next_half_on;
  logic [3:0]                  ovp_cnt, next_ovp_cnt;
  logic                        next_clr_en;
  logic                        prot_off, next_prot_off;
  wbc_pkg::wbc_ctl_t           next_ctl;

  logic ctrl_rise;
  logic bit_rise;
  logic want_on;
  logic protect;
  logic start_edge;

  // Request decoding
  always_comb begin
    ctrl_rise = ctrl_s && !ctrl_d;
    bit_rise  = i_enable_bit && !bit_d;
    // Bit wins; otherwise pin edge starts and holds driver
    want_on   = i_enable_bit || (ctrl_s || !low_long);
    protect   = uvlo_s || hot_s;
    start_edge = bit_rise || (ctrl_rise && !i_enable_bit);
  end

  // Low-time measurement of the control pin
  always_comb begin
    next_ctrl_d = ctrl_s;
    next_bit_d  = i_enable_bit;
    if (ctrl_s) begin
      next_low_cnt  = '0;
      next_low_long = 1'b0;
    end else if (low_cnt >= OFF_LAST) begin
      next_low_cnt  = low_cnt;
      next_low_long = 1'b1;
    end else begin
      next_low_cnt  = low_cnt + 1'b1;
      next_low_long = low_long;
    end
  end

  // Driver state machine
  always_comb begin
    next_state    = state;
    next_clr_en   = 1'b0;
    next_step_cnt = step_cnt;
    next_ss_idx   = ss_idx;
    next_half_cnt = half_cnt;
    next_half_on  = half_on;
    next_ovp_cnt  = ovp_cnt;
    next_prot_off = prot_off;
    unique case (state)
      wbc_pkg::WBC_OFF: begin
        // Fresh edge, or automatic return once protection releases
        if (!protect && (start_edge || (prot_off && want_on))) begin
          next_state    = wbc_pkg::WBC_RAMP;
          next_step_cnt = '0;
          next_ss_idx   = '0;
          next_half_cnt = '0;
          next_half_on  = 1'b1;
          next_ovp_cnt  = '0;
          next_prot_off = 1'b0;
        end else if (!want_on) begin
          next_prot_off = 1'b0;
        end
      end
      wbc_pkg::WBC_RAMP, wbc_pkg::WBC_RUN: begin
        if (state == wbc_pkg::WBC_RAMP) begin
          if (step_cnt == STEP_LAST) begin
            next_step_cnt = '0;
            if (ss_idx == SS_LAST)
              next_state = wbc_pkg::WBC_RUN;
            else
              next_ss_idx = ss_idx + 1'b1;
          end else begin
            next_step_cnt = step_cnt + 1'b1;
          end
        end
        if (half_on) begin
          if (half_cnt == HALF_LAST)
            next_half_on = 1'b0;
          else
            next_half_cnt = half_cnt + 1'b1;
        end
        if (sw_tick)
          next_ovp_cnt = ovp_s ? ovp_cnt + 1'b1 : '0;
        if (flt_s) begin
          next_state  = wbc_pkg::WBC_FAULT;
          next_clr_en = 1'b1;
        end else if (next_ovp_cnt >= OVP_LAST) begin
          next_state  = wbc_pkg::WBC_OPEN;
        end else if (protect) begin
          // Remember the cause so release restarts the driver
          next_state    = wbc_pkg::WBC_OFF;
          next_prot_off = 1'b1;
        end else if (!want_on) begin
          next_state  = wbc_pkg::WBC_OFF;
        end
      end
      wbc_pkg::WBC_FAULT: begin
        next_clr_en = 1'b0;
        if (low_long)
          next_state = wbc_pkg::WBC_OFF;
      end
      wbc_pkg::WBC_OPEN: begin
        // A fresh edge of pin or bit, or bit clear with pin low 2.5 ms, leads back
        if (bit_rise || ctrl_rise || (!i_enable_bit && low_long))
          next_state = wbc_pkg::WBC_OFF;
      end
      default: next_state = wbc_pkg::WBC_OFF;
    endcase
  end

  // Outputs to the power stage
  always_comb begin
    sw_run = (state == wbc_pkg::WBC_RAMP) || (state == wbc_pkg::WBC_RUN);
    next_ctl.active    = bus_s || sw_run
                         || (next_state == wbc_pkg::WBC_RAMP);
    next_ctl.drv_on    = sw_run;
    next_ctl.sw_gate   = sw_run && sw_gate && !protect;
    next_ctl.half_ilim = sw_run && half_on;
    // Ramp limits the code; steady code follows the register
    if (state == wbc_pkg::WBC_RAMP && ss_idx[4:0] < i_ref_code)
      next_ctl.ref_code = ss_idx[4:0];
    else
      next_ctl.ref_code = sw_run ? i_ref_code : '0;
    next_ctl.ref_chop  = sw_run && (i_enable_bit || ctrl_s);
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state        <= wbc_pkg::WBC_OFF;
      ctrl_d       <= 1'b0;
      bit_d        <= 1'b0;
      low_cnt      <= '0;
      low_long     <= 1'b1;
      step_cnt     <= '0;
      ss_idx       <= '0;
      half_cnt     <= '0;
      half_on      <= 1'b0;
      ovp_cnt      <= '0;
      prot_off     <= 1'b0;
      o_ctl        <= '0;
      o_state      <= wbc_pkg::WBC_OFF;
      o_clr_enable <= 1'b0;
    end else begin
      state        <= next_state;
      ctrl_d       <= next_ctrl_d;
      bit_d        <= next_bit_d;
      low_cnt      <= next_low_cnt;
      low_long     <= next_low_long;
      step_cnt     <= next_step_cnt;
      ss_idx       <= next_ss_idx;
      half_cnt     <= next_half_cnt;
      half_on      <= next_half_on;
      ovp_cnt      <= next_ovp_cnt;
      prot_off     <= next_prot_off;
      o_ctl        <= next_ctl;
      o_state      <= next_state;
      o_clr_enable <= next_clr_en;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bit_priority;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sw_run && i_enable_bit && !flt_s && !protect
       && !ovp_s) |=> state != wbc_pkg::WBC_OFF;
  endproperty
  a_bit_priority: assert property (p_bit_priority)
    else $error("Enable bit did not hold driver on");

  property p_low_shut;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sw_run && !i_enable_bit && low_long && !flt_s)
      |=> state inside {wbc_pkg::WBC_OFF, wbc_pkg::WBC_OPEN};
  endproperty
  a_low_shut: assert property (p_low_shut)
    else $error("Driver not shut after long low");

  property p_fault_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sw_run && flt_s) |=> (state == wbc_pkg::WBC_FAULT) && o_clr_enable;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("Fault did not latch and clear enable");

  property p_fault_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == wbc_pkg::WBC_FAULT && !low_long)
      |=> state == wbc_pkg::WBC_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("Fault released early");

  property p_protect_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      protect |=> !o_ctl.sw_gate;
  endproperty
  a_protect_gate: assert property (p_protect_gate)
    else $error("Switch on under protection");

  property p_hot_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sw_run && hot_s && !flt_s && !ovp_s) |=> state == wbc_pkg::WBC_OFF;
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("Over-temperature did not shut down");

  property p_ramp_steady;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == wbc_pkg::WBC_RAMP && step_cnt != STEP_LAST
       && $past(state) == wbc_pkg::WBC_RAMP) |=> $stable(ss_idx);
  endproperty
  a_ramp_steady: assert property (p_ramp_steady)
    else $error("Ramp step changed early");

  property p_open_latch;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == wbc_pkg::WBC_OPEN && !bit_rise && !ctrl_rise && !low_long)
      |=> state == wbc_pkg::WBC_OPEN;
  endproperty
  a_open_latch: assert property (p_open_latch)
    else $error("Open shutdown left without toggle");

  property p_active;
    @(posedge i_clk) disable iff (!i_rst_n)
      bus_s |=> o_ctl.active;
  endproperty
  a_active: assert property (p_active)
    else $error("Not active with bus power");

  c_ramp_done:  cover property (@(posedge i_clk)
                  state == wbc_pkg::WBC_RUN);
  c_fault:      cover property (@(posedge i_clk)
                  state == wbc_pkg::WBC_FAULT);
  c_open:       cover property (@(posedge i_clk)
                  state == wbc_pkg::WBC_OPEN);
  c_pin_off:    cover property (@(posedge i_clk)
                  state == wbc_pkg::WBC_RUN ##1 state == wbc_pkg::WBC_OFF);
endmodule

/* sim/wbc_host.sv */
// Purpose : Host side of the dimming control pin
// Assumes : Pin changes on the falling clock edge
// Notes   : PWM mode gives a 50 percent duty, period of 4 cycles
`timescale 1ns/1ps
module wbc_host (
  input  wire logic i_clk,      // System clock
  input  wire logic i_level,    // Steady pin level wanted
  input  wire logic i_pwm,      // Drive a PWM pattern instead
  output logic      o_ctrl_pin  // Dimming control pin
);
  logic [1:0] phase;

  // Pin starts low so power-up sees no edge
  initial begin
    o_ctrl_pin = 1'b0;
    phase      = 2'h0;
  end

  // Steady level or chopped pattern
  always @(negedge i_clk) begin
    phase      <= phase + 2'h1;
    o_ctrl_pin <= i_pwm ? phase[1] : i_level;
  end
endmodule

/* sim/testbench.sv */
// Purpose : Self-checking bench for the LED boost control block
// Assumes : 10 MHz clock, inputs change on the falling edge
// Notes   : Long counts run at full length, about 102k cycles
`timescale 1ns/1ps
module testbench;
  logic                clk;
  logic                rst_n;
  logic                pin_lvl;
  logic                pwm_en;
  logic                ctrl_pin;
  logic                en_bit;
  logic                bus_pwr;
  logic [4:0]          ref_cd;
  wbc_pkg::wbc_prot_t  prot;
  wbc_pkg::wbc_ctl_t   ctl;
  wbc_pkg::wbc_state_t state;
  logic                clr;
  int                  error_cnt;
  int                  num_checks;

  // ----------------------------------------------------------------
  // Clock, host model and design
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;

  wbc_host u_wbc_host (
    .i_clk      (clk),
    .i_level    (pin_lvl),
    .i_pwm      (pwm_en),
    .o_ctrl_pin (ctrl_pin)
  );

  wbc_top u_wbc_top (
    .i_clk        (clk),
    .i_rst_n      (rst_n),
    .i_ctrl_pin   (ctrl_pin),
    .i_enable_bit (en_bit),
    .i_enable_wr  (1'b0),
    .i_ref_code   (ref_cd),
    .i_bus_power  (bus_pwr),
    .i_prot       (prot),
    .o_ctl        (ctl),
    .o_state      (state),
    .o_clr_enable (clr)
  );

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Wait for a state under a bounded count; the caller compares it
  task automatic wait_st(input wbc_pkg::wbc_state_t s, input int lim,
                         output int n);
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Start by the bit, pin ignored, soft start and halved limit
  task automatic t_bit_start;
    int n;
    int hi;
    chk("reset state", 32'(state), 32'(wbc_pkg::WBC_OFF));
    chk("standby active", 32'(ctl.active), 32'h0);
    en_bit = 1'b1;
    wait_st(wbc_pkg::WBC_RAMP, 5, n);
    chk("bit start", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    cyc(1);
    chk("active on", 32'(ctl.active), 32'h1);
    chk("half limit", 32'(ctl.half_ilim), 32'h1);
    chk("first step", 32'(ctl.ref_code), 32'h0);
    pin_lvl = 1'b1;
    cyc(10);
    pin_lvl = 1'b0;
    cyc(2090);
    chk("pin ignored", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    chk("step held", 32'(ctl.ref_code), 32'h0);
    cyc(60);
    chk("second step", 32'(ctl.ref_code), 32'h1);
    hi = 0;
    for (int i = 0; i < 160; i++) begin
      @(negedge clk);
      hi += int'(ctl.sw_gate);
    end
    chk("gate duty", 32'(hi), 32'd80);
    cyc(21400 - 2320);
    chk("ref capped", 32'(ctl.ref_code), 32'h0a);
    ref_cd = 5'h04;
    cyc(2);
    chk("ref follows", 32'(ctl.ref_code), 32'h04);
    ref_cd = 5'h0a;
    cyc(49980 - 21400);
    chk("half held", 32'(ctl.half_ilim), 32'h1);
    cyc(40);
    chk("half ended", 32'(ctl.half_ilim), 32'h0);
  endtask

  // Overvoltage on eight ticks, then restart by bit toggle
  task automatic t_ovp;
    int n;
    prot.ovp = 1'b1;
    wait_st(wbc_pkg::WBC_OPEN, 200, n);
    chk("open state", 32'(state), 32'(wbc_pkg::WBC_OPEN));
    chk("open not early", 32'(n >= 100), 32'h1);
    cyc(1);
    chk("open gate", 32'(ctl.sw_gate), 32'h0);
    prot.ovp = 1'b0;
    cyc(20);
    chk("open held", 32'(state), 32'(wbc_pkg::WBC_OPEN));
    en_bit = 1'b0;
    cyc(3);
    en_bit = 1'b1;
    wait_st(wbc_pkg::WBC_RAMP, 10, n);
    chk("bit restart", 32'(state), 32'(wbc_pkg::WBC_RAMP));
  endtask

  // Fault clears the bit and holds until the pin is low long enough
  task automatic t_fault;
    int n;
    int pulses;
    pin_lvl = 1'b1;
    cyc(10);
    chk("pin ignored high", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    prot.fault = 1'b1;
    pulses = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      pulses += int'(clr);
    end
    chk("clear pulse", 32'(pulses), 32'd1);
    chk("fault state", 32'(state), 32'(wbc_pkg::WBC_FAULT));
    chk("fault drv", 32'(ctl.drv_on), 32'h0);
    prot.fault = 1'b0;
    en_bit = 1'b0;
    pin_lvl = 1'b0;
    cyc(24000);
    chk("fault held", 32'(state), 32'(wbc_pkg::WBC_FAULT));
    wait_st(wbc_pkg::WBC_OFF, 1200, n);
    chk("fault release", 32'(state), 32'(wbc_pkg::WBC_OFF));
  endtask

  // Pin edge starts the driver; reference chopped by the pin
  task automatic t_pin_start;
    int n;
    int hi;
    pin_lvl = 1'b1;
    wait_st(wbc_pkg::WBC_RAMP, 8, n);
    chk("pin start", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    cyc(1);
    chk("chop high", 32'(ctl.ref_chop), 32'h1);
    pwm_en = 1'b1;
    cyc(8);
    hi = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      hi += int'(ctl.ref_chop);
    end
    chk("chop duty", 32'(hi), 32'd32);
    pwm_en = 1'b0;
    cyc(8);
  endtask

  // Undervoltage and over-temperature stop the driver; release restarts it
  task automatic t_prot;
    int n;
    prot.uvlo = 1'b1;
    cyc(5);
    chk("uvlo drv", 32'(ctl.drv_on), 32'h0);
    chk("uvlo gate", 32'(ctl.sw_gate), 32'h0);
    prot.uvlo = 1'b0;
    wait_st(wbc_pkg::WBC_RAMP, 8, n);
    chk("uvlo restart", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    prot.hot = 1'b1;
    cyc(5);
    chk("hot drv", 32'(ctl.drv_on), 32'h0);
    prot.hot = 1'b0;
    wait_st(wbc_pkg::WBC_RAMP, 8, n);
    chk("hot release", 32'(state), 32'(wbc_pkg::WBC_RAMP));
  endtask

  // Low-time restarts on a high pulse; long low shuts down
  task automatic t_lowtime;
    int n;
    pin_lvl = 1'b0;
    cyc(1500);
    pin_lvl = 1'b1;
    cyc(3);
    pin_lvl = 1'b0;
    cyc(24000);
    chk("low restart", 32'(state), 32'(wbc_pkg::WBC_RAMP));
    wait_st(wbc_pkg::WBC_OFF, 1200, n);
    chk("low shutdown", 32'(state), 32'(wbc_pkg::WBC_OFF));
    cyc(3);
    chk("standby", 32'(ctl.active), 32'h0);
    bus_pwr = 1'b1;
    cyc(5);
    chk("bus active", 32'(ctl.active), 32'h1);
    chk("bus no drv", 32'(ctl.drv_on), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    error_cnt  = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    pin_lvl    = 1'b0;
    pwm_en     = 1'b0;
    en_bit     = 1'b0;
    bus_pwr    = 1'b0;
    ref_cd     = 5'h0a;
    prot       = '0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    t_bit_start();
    t_ovp();
    t_fault();
    t_pin_start();
    t_prot();
    t_lowtime();
    results();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(64'd130000 * 64'd100);
    error_cnt++;
    results();
  end
endmodule
